/* File: src/discrete_io_pkg.sv */
// constants for the board discrete i/o port decode
package discrete_io_pkg;
	// i/o space byte addresses
	localparam logic [15:0] ADDR_LINE_DRIVER = 16'h4140;
	localparam logic [15:0] ADDR_RUN_LAMP = 16'h4141;
	localparam logic [15:0] ADDR_USER_LAMP = 16'h4142;
	localparam logic [15:0] ADDR_FIRST_RELAY = 16'h4143;
	localparam logic [15:0] ADDR_SECOND_RELAY = 16'h4144;
	localparam logic [15:0] ADDR_GROUP_A = 16'h4145;
	localparam logic [15:0] ADDR_GROUP_B = 16'h4146;
	localparam logic [15:0] ADDR_CONV_SELECT = 16'h4147;
	// read-side aliases of the same addresses
	localparam logic [15:0] ADDR_RD_INPUTS = 16'h4140;
	localparam logic [15:0] ADDR_RD_OUT_STATES = 16'h4141;
	localparam logic [15:0] ADDR_RD_CONV_IN_A = 16'h4142;
	localparam logic [15:0] ADDR_RD_CONV_IN_B = 16'h4143;
	localparam logic [15:0] ADDR_RD_CONV_DONE = 16'h4144;
	// field positions
	localparam int ON_BIT = 0;
	localparam int GROUP_IDX_LSB = 0;
	localparam int GROUP_IDX_W = 3;
	localparam int GROUP_STATE_BIT = 7;
	localparam int GROUP_DRIVERS = 6;
	localparam int STATUS_BIT = 0;
	// output state bit order at the output-state read
	localparam int OST_LINE_DRIVER = 0;
	localparam int OST_RUN_LAMP = 1;
	localparam int OST_USER_LAMP = 2;
	localparam int OST_FIRST_RELAY = 3;
	localparam int OST_SECOND_RELAY = 4;
	localparam int OST_CONV_SELECT = 5;
	// reset values
	localparam logic OUT_RESET = 1'b0;
	localparam logic [5:0] GROUP_RESET = 6'h00;
	localparam logic [7:0] RDATA_RESET = 8'h00;
	// synchroniser depth for pin inputs
	localparam int SYNC_STAGES = 3;
endpackage

/* File: src/pin_sync_if.sv */
// carrier between the port decode and its pin input filter
`timescale 1ns/1ps
interface pin_sync_if #(parameter int W = 10);
	logic [W-1:0] raw;
	logic [W-1:0] clean;
	modport filter (input raw, output clean);
	modport user (output raw, input clean);
endinterface

/* File: src/pin_input_filter.sv */
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module pin_input_filter
	import discrete_io_pkg::*;
#(
	parameter int W = 10
) (
	input wire logic mclk,
	input wire logic rstn,
	pin_sync_if.filter pins
);
	// refused at elaboration: a zero-width filter has nothing to hold
	if (W < 1) begin : g_bad_width
		$error("pin_input_filter: width must be at least 1");
	end

	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] clean_r;
	logic [W-1:0] clean_nxt;

	// only the agreeing later stages may update the clean value
	genvar i;
	for (i = 0; i < W; i++) begin : g_bit
		assign clean_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : clean_r[i];
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			clean_r <= '0;
		end else begin
			s1_r <= pins.raw;
			s2_r <= s1_r;
			s3_r <= s2_r;
			clean_r <= clean_nxt;
		end
	end

	assign pins.clean = clean_r;
endmodule

/* File: src/board_discrete_io_port.sv */
// i/o space decode for the board's discrete outputs, drivers and inputs
`timescale 1ns/1ps
module board_discrete_io_port
	import discrete_io_pkg::*;
#(
	parameter int IN_W = 8
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [15:0] io_addr,
	input wire logic [7:0] io_wdata,
	input wire logic io_wr,
	input wire logic io_rd,
	output logic [7:0] io_rdata,
	input wire logic [IN_W-1:0] digital_inputs,
	input wire logic converter_data_in,
	input wire logic conversion_done,
	output logic line_driver_en,
	output logic run_lamp,
	output logic user_lamp,
	output logic first_relay,
	output logic second_relay,
	output logic [GROUP_DRIVERS-1:0] driver_group_a,
	output logic [GROUP_DRIVERS-1:0] driver_group_b,
	output logic converter_select_n
);
	// refused at elaboration: the input read is a single data byte
	if (IN_W != 8) begin : g_bad_width
		$error("board_discrete_io_port: input read is one byte wide");
	end

	localparam int SYNC_W = IN_W + 2;

	// group write helper: one-hot mask of the addressed driver
	function automatic logic [GROUP_DRIVERS-1:0] group_mask(input logic [7:0] d);
		logic [GROUP_DRIVERS-1:0] m;
		m = '0;
		for (int k = 0; k < GROUP_DRIVERS; k++) begin
			if (d[GROUP_IDX_LSB +: GROUP_IDX_W] == k[GROUP_IDX_W-1:0]) begin
				m[k] = 1'b1;
			end
		end
		return m;
	endfunction

	// apply a group write; an index past the last driver yields no mask
	function automatic logic [GROUP_DRIVERS-1:0] group_apply(
		input logic [GROUP_DRIVERS-1:0] cur,
		input logic [7:0] d
	);
		logic [GROUP_DRIVERS-1:0] m;
		m = group_mask(d);
		return d[GROUP_STATE_BIT] ? (cur | m) : (cur & ~m);
	endfunction

	pin_sync_if #(.W(SYNC_W)) pin_bus ();

	pin_input_filter #(.W(SYNC_W)) u_filter (
		.mclk(mclk),
		.rstn(rstn),
		.pins(pin_bus)
	);

	assign pin_bus.raw = {conversion_done, converter_data_in, digital_inputs};

	wire [IN_W-1:0] inputs_clean = pin_bus.clean[IN_W-1:0];
	wire conv_in_clean = pin_bus.clean[IN_W];
	wire conv_done_clean = pin_bus.clean[IN_W+1];

	logic line_drv_r;
	logic run_lamp_r;
	logic user_lamp_r;
	logic relay0_r;
	logic relay1_r;
	logic conv_sel_r;
	logic [GROUP_DRIVERS-1:0] grp_a_r;
	logic [GROUP_DRIVERS-1:0] grp_b_r;
	logic [7:0] rdata_r;

	// write decode
	wire wr_line = io_wr && (io_addr == ADDR_LINE_DRIVER);
	wire wr_run = io_wr && (io_addr == ADDR_RUN_LAMP);
	wire wr_user = io_wr && (io_addr == ADDR_USER_LAMP);
	wire wr_rel0 = io_wr && (io_addr == ADDR_FIRST_RELAY);
	wire wr_rel1 = io_wr && (io_addr == ADDR_SECOND_RELAY);
	wire wr_grp_a = io_wr && (io_addr == ADDR_GROUP_A);
	wire wr_grp_b = io_wr && (io_addr == ADDR_GROUP_B);
	wire wr_csel = io_wr && (io_addr == ADDR_CONV_SELECT);
	wire wr_bit = io_wdata[ON_BIT];

	// next values of the single outputs
	wire line_drv_nxt = wr_line ? wr_bit : line_drv_r;
	wire run_lamp_nxt = wr_run ? wr_bit : run_lamp_r;
	wire user_lamp_nxt = wr_user ? wr_bit : user_lamp_r;
	wire relay0_nxt = wr_rel0 ? wr_bit : relay0_r;
	wire relay1_nxt = wr_rel1 ? wr_bit : relay1_r;
	wire conv_sel_nxt = wr_csel ? wr_bit : conv_sel_r;

	// group drivers: indexed bit, state in bit 7, rest held
	wire [GROUP_DRIVERS-1:0] grp_a_nxt = wr_grp_a ?
		group_apply(grp_a_r, io_wdata) : grp_a_r;
	wire [GROUP_DRIVERS-1:0] grp_b_nxt = wr_grp_b ?
		group_apply(grp_b_r, io_wdata) : grp_b_r;

	wire [7:0] out_states = {2'b00, conv_sel_r, relay1_r, relay0_r,
		user_lamp_r, run_lamp_r, line_drv_r};

	// read decode; write-only and unmapped addresses read as zero
	wire rd_inputs = (io_addr == ADDR_RD_INPUTS);
	wire rd_outs = (io_addr == ADDR_RD_OUT_STATES);
	wire rd_conv_in = (io_addr == ADDR_RD_CONV_IN_A) || (io_addr == ADDR_RD_CONV_IN_B);
	wire rd_done = (io_addr == ADDR_RD_CONV_DONE);
	wire [7:0] rd_mux = rd_inputs ? inputs_clean :
		rd_outs ? out_states :
		rd_conv_in ? {7'h00, conv_in_clean} :
		rd_done ? {7'h00, conv_done_clean} :
		8'h00;
	// read data holds between reads so a slow host can sample late
	wire [7:0] rdata_nxt = io_rd ? rd_mux : rdata_r;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			line_drv_r <= OUT_RESET;
			run_lamp_r <= OUT_RESET;
			user_lamp_r <= OUT_RESET;
			relay0_r <= OUT_RESET;
			relay1_r <= OUT_RESET;
			conv_sel_r <= OUT_RESET;
		end else begin
			line_drv_r <= line_drv_nxt;
			run_lamp_r <= run_lamp_nxt;
			user_lamp_r <= user_lamp_nxt;
			relay0_r <= relay0_nxt;
			relay1_r <= relay1_nxt;
			conv_sel_r <= conv_sel_nxt;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			grp_a_r <= GROUP_RESET;
			grp_b_r <= GROUP_RESET;
			rdata_r <= RDATA_RESET;
		end else begin
			grp_a_r <= grp_a_nxt;
			grp_b_r <= grp_b_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign line_driver_en = line_drv_r;
	assign run_lamp = run_lamp_r;
	assign user_lamp = user_lamp_r;
	assign first_relay = relay0_r;
	assign second_relay = relay1_r;
	assign driver_group_a = grp_a_r;
	assign driver_group_b = grp_b_r;
	// select pin is active low: "on" pulls it down
	assign converter_select_n = ~conv_sel_r;
	assign io_rdata = rdata_r;

	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	wire [GROUP_DRIVERS-1:0] chk_mask = group_mask(io_wdata);
	wire chk_bad_idx = io_wdata[GROUP_IDX_LSB +: GROUP_IDX_W] >= GROUP_IDX_W'(GROUP_DRIVERS);

	AST_RELAY_FOLLOWS: assert property (
		wr_rel0 |=> (first_relay == $past(io_wdata[ON_BIT])) && $stable(second_relay))
		else $error("first relay did not follow write bit 0");
	AST_LINE_FOLLOWS: assert property (
		wr_line |=> line_driver_en == $past(io_wdata[ON_BIT]))
		else $error("line driver enable did not follow write bit 0");
	AST_RUN_LAMP_FOLLOWS: assert property (
		wr_run |=> run_lamp == $past(io_wdata[ON_BIT]))
		else $error("run lamp did not follow write bit 0");
	AST_USER_LAMP_FOLLOWS: assert property (
		wr_user |=> user_lamp == $past(io_wdata[ON_BIT]))
		else $error("user lamp did not follow write bit 0");
	AST_RELAY1_FOLLOWS: assert property (
		wr_rel1 |=> second_relay == $past(io_wdata[ON_BIT]))
		else $error("second relay did not follow write bit 0");
	AST_CSEL_ACTIVE_LOW: assert property (
		wr_csel |=> converter_select_n == !$past(io_wdata[ON_BIT]))
		else $error("converter select pin wrong after write");
	AST_GROUP_INDEXED: assert property (
		(wr_grp_a && !chk_bad_idx) |=>
		((driver_group_a & $past(chk_mask)) != '0) == $past(io_wdata[GROUP_STATE_BIT]))
		else $error("indexed group a driver has wrong state");
	AST_GROUP_OTHERS_KEPT: assert property (
		wr_grp_b |=> (driver_group_b & ~$past(chk_mask)) ==
		($past(driver_group_b) & ~$past(chk_mask)))
		else $error("group b write disturbed other drivers");
	AST_GROUP_BAD_INDEX: assert property (
		(wr_grp_a && chk_bad_idx) |=> $stable(driver_group_a) ##1
		($past(wr_grp_a) || $stable(driver_group_a)))
		else $error("group a changed on out-of-range index");
	AST_GROUP_B_BAD_INDEX: assert property (
		(wr_grp_b && chk_bad_idx) |=> $stable(driver_group_b))
		else $error("group b changed on out-of-range index");
	AST_READ_INPUTS: assert property (
		(io_rd && rd_inputs) |=> io_rdata == $past(inputs_clean))
		else $error("input read returned wrong data");
	AST_READ_OUT_STATES: assert property (
		(io_rd && rd_outs) |=> io_rdata[OST_RUN_LAMP] == $past(run_lamp) &&
		io_rdata[OST_CONV_SELECT] == !$past(converter_select_n))
		else $error("output state read mismatch");
	AST_READ_DONE: assert property (
		(io_rd && rd_done) |=> io_rdata == {7'h00, $past(conv_done_clean)})
		else $error("conversion done read mismatch");
	AST_READ_CONV_IN: assert property (
		(io_rd && rd_conv_in) |=> io_rdata == {7'h00, $past(conv_in_clean)})
		else $error("converter data read mismatch");

	COV_GROUP_ON: cover property (wr_grp_a && io_wdata[GROUP_STATE_BIT] ##1 driver_group_a != '0);
	COV_GROUP_BAD: cover property (wr_grp_b && chk_bad_idx);
	COV_READ_OUTS: cover property (wr_rel1 ##[1:3] (io_rd && rd_outs));
	COV_READ_CONV: cover property (io_rd && rd_conv_in);
endmodule

/* File: tb/io_host_model.sv */
// host-side i/o bus model for the port decode
`timescale 1ns/1ps
module io_host_model (
	input wire logic mclk,
	output logic [15:0] io_addr,
	output logic [7:0] io_wdata,
	output logic io_wr,
	output logic io_rd,
	input wire logic [7:0] io_rdata
);
	initial begin
		io_addr = 16'h0000;
		io_wdata = 8'h00;
		io_wr = 1'b0;
		io_rd = 1'b0;
	end
	// idle bus shows inverted values so stale data never passes as valid
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge mclk);
		io_addr = a;
		io_wdata = d;
		io_wr = 1'b1;
		@(negedge mclk);
		io_wr = 1'b0;
		io_addr = ~a;
		io_wdata = ~d;
	endtask
	// data taken in the cycle after the read edge, before the strobe drops
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(negedge mclk);
		io_addr = a;
		io_rd = 1'b1;
		@(negedge mclk);
		d = io_rdata;
		io_rd = 1'b0;
		io_addr = ~a;
	endtask
endmodule

/* File: tb/board_discrete_io_port_tb_top.sv */
// self-checking bench for the board discrete i/o port decode
`timescale 1ns/1ps
module board_discrete_io_port_tb_top
	import discrete_io_pkg::*;
;
	typedef struct packed {logic [15:0] addr; logic [7:0] d; logic [7:0] ost;} row_t;
	logic mclk, rstn, io_wr, io_rd, converter_data_in, conversion_done;
	logic [15:0] io_addr;
	logic [7:0] io_wdata, io_rdata, digital_inputs, rdv;
	logic line_driver_en, run_lamp, user_lamp, first_relay, second_relay, converter_select_n;
	logic [5:0] driver_group_a, driver_group_b;
	int num_errors = 0;
	int num_checks = 0;
	wire logic [7:0] pins_w = {2'b00, ~converter_select_n, second_relay, first_relay,
		user_lamp, run_lamp, line_driver_en};
	row_t rows [8] = '{'{16'h4140, 8'h01, 8'h01}, '{16'h4141, 8'h01, 8'h03},
		'{16'h4142, 8'hFF, 8'h07}, '{16'h4143, 8'h01, 8'h0F}, '{16'h4144, 8'h01, 8'h1F},
		'{16'h4147, 8'h01, 8'h3F}, '{16'h4141, 8'hFE, 8'h3D}, '{16'h4147, 8'h00, 8'h1D}};
	io_host_model host (.mclk(mclk), .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr),
		.io_rd(io_rd), .io_rdata(io_rdata));
	board_discrete_io_port dut (.mclk(mclk), .rstn(rstn), .io_addr(io_addr),
		.io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
		.digital_inputs(digital_inputs), .converter_data_in(converter_data_in),
		.conversion_done(conversion_done), .line_driver_en(line_driver_en),
		.run_lamp(run_lamp), .user_lamp(user_lamp), .first_relay(first_relay),
		.second_relay(second_relay), .driver_group_a(driver_group_a),
		.driver_group_b(driver_group_b), .converter_select_n(converter_select_n));
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic gw(input logic [15:0] a, input logic [7:0] d, input logic [5:0] ea,
		input logic [5:0] eb);
		host.wr(a, d);
		chk("group a", {2'b00, driver_group_a}, {2'b00, ea});
		chk("group b", {2'b00, driver_group_b}, {2'b00, eb});
	endtask
	task automatic rc(input logic [15:0] a, input logic [7:0] exp);
		host.rd(a, rdv);
		chk("read data", rdv, exp);
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// no wait below is open-ended; this only guards against a stuck run
	initial begin
		#200000;
		num_errors++;
		end_of_test();
	end
	initial begin
		rstn = 1'b0;
		digital_inputs = 8'h00;
		converter_data_in = 1'b0;
		conversion_done = 1'b0;
		repeat (3) @(posedge mclk);
		@(negedge mclk) rstn = 1'b1;
		chk("reset pins", pins_w, 8'h00);
		chk("reset read data", io_rdata, 8'h00);
		chk("reset group", {2'b00, driver_group_a | driver_group_b}, 8'h00);
		for (int i = 0; i < 8; i++) begin
			host.wr(rows[i].addr, rows[i].d);
			chk("output pins", pins_w, rows[i].ost);
			rc(ADDR_RD_OUT_STATES, rows[i].ost);
		end
		$display("test single outputs done");
		gw(ADDR_GROUP_A, 8'h82, 6'h04, 6'h00);
		gw(ADDR_GROUP_A, 8'h85, 6'h24, 6'h00);
		gw(ADDR_GROUP_A, 8'h86, 6'h24, 6'h00);
		gw(ADDR_GROUP_A, 8'h07, 6'h24, 6'h00);
		gw(ADDR_GROUP_A, 8'h02, 6'h20, 6'h00);
		gw(ADDR_GROUP_B, 8'h80, 6'h20, 6'h01);
		gw(ADDR_GROUP_B, 8'hFF, 6'h20, 6'h01);
		$display("test driver groups done");
		// pins pass a synchroniser, so allow settling first
		digital_inputs = 8'hA5;
		converter_data_in = 1'b1;
		repeat (6) @(negedge mclk);
		rc(ADDR_RD_INPUTS, 8'hA5);
		rc(ADDR_RD_CONV_IN_A, 8'h01);
		rc(ADDR_RD_CONV_IN_B, 8'h01);
		rc(ADDR_RD_CONV_DONE, 8'h00);
		digital_inputs = 8'h5A;
		converter_data_in = 1'b0;
		conversion_done = 1'b1;
		repeat (6) @(negedge mclk);
		rc(ADDR_RD_INPUTS, 8'h5A);
		rc(ADDR_RD_CONV_IN_A, 8'h00);
		rc(ADDR_RD_CONV_IN_B, 8'h00);
		rc(ADDR_RD_CONV_DONE, 8'h01);
		$display("test input reads done");
		host.wr(16'h4148, 8'hFF);
		rc(16'h4148, 8'h00);
		rc(ADDR_GROUP_A, 8'h00);
		rc(ADDR_RD_OUT_STATES, 8'h1D);
		$display("test refused access done");
		@(negedge mclk) rstn = 1'b0;
		#1;
		chk("reset pins", pins_w, 8'h00);
		chk("reset group", {2'b00, driver_group_a | driver_group_b}, 8'h00);
		@(negedge mclk) rstn = 1'b1;
		gw(ADDR_GROUP_B, 8'h85, 6'h00, 6'h20);
		$display("test mid-run reset done");
		end_of_test();
	end
endmodule
